// ### verilog/rftx_ctrl.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - High chip selects the upper FSK tone, low chip the lower tone.
// - Tone offset is deviation times 95 in steps of crystal over 2^23.
// - Twelve-bit divider sets the Gaussian sample rate; 16x oversampling advised.
// - Gaussian option smooths tone steps; higher oversampling smooths less.
// - Controller switches the amplifier itself; in processor mode software uses manual enable.
// - FSK ramps amplifier impedance up and down at the ramp time setting.
// - Bypass bit selects battery voltage for the amplifier supply pin.
// - FSK and OOK hold the supply DAC at the supply level setting.
// - ASK moves the supply as a trapezoid between low and high levels.
// - Each ASK ramp lasts level span over crystal times slope plus fraction.
// - Oscillator boost is off after reset and follows the boost bit.
// - Controller waits the start-up count, then reports the stable flag.
// - Manchester bit rate is crystal over eight times baud divider plus one.
// - Chip rate is twice the Manchester bit rate; NRZ sends one bit per chip.
// - Controller enabled first; processor halted while payload bytes are fetched.
// - Center frequency is crystal times integer plus fraction over 2^21.
// - Baud ticks clock the encoder, which sends each byte MSB first.
module rftx_ctrl (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Register port
  input  wire rftx_pkg::rftx_bus_type bus,
  output logic [31:0]                rd_data_r,
  // Payload RAM
  output logic [7:0]                 ram_addr_r,
  output logic                       ram_rd_r,
  input  wire logic [7:0]            ram_rdata,
  // Processor
  output logic                       cpu_halt_r,
  // Oscillator
  output logic                       osc_enable_r,
  output logic                       osc_boost_enable_r,
  // Amplifier
  output logic                       amp_enable_r,
  output logic                       amp_bypass_r,
  output logic [7:0]                 amp_imp_level_r,
  output logic [7:0]                 amp_supply_pin_r,
  // Modulation
  output logic                       mod_data_r,
  output logic [30:0]                sdm_freq_word_r
);
  import rftx_pkg::*;

  typedef enum {ST_IDLE, ST_START, ST_FETCH, ST_LOAD, ST_RAMPUP, ST_SEND, ST_RAMPDN}
    rftx_state_type;

  rftx_state_type state_r, state_nxt;
  rftx_cfg_type   cfg_r;
  logic [7:0]     ctrl_r, fsk_deviation_step_r, cint_r, asup_r, amp_ramp_time_r, alo_r, ahi_r, slope_r, plen_r;
  logic [15:0]    baud_r, stup_r, wcnt_r;
  logic [11:0]    gdiv_r, gcnt_r;
  logic [20:0]    cfrac_r;
  logic [3:0]     rdiv_r, hist_r, wsum, w;
  logic [17:0]    ccnt_r;
  logic [7:0]     sh_r, pre_r, byte_r, icnt_r, imp_tgt, ask_tgt, ask_lvl;
  logic [2:0]     bit_r;
  logic           half_r, rd_d_r, stable_r, go, chip_tick, byte_end, tx_on, enc;
  logic [14:0]    dev;
  logic signed [20:0] prod;
  logic [30:0]    cw, sdm_nxt;

  function automatic logic wr_hit(input rftx_bus_type b, input logic [7:0] off);
    return b.wr && (b.addr == off);
  endfunction

  // start needs the enable bit already set
  assign go = wr_hit(bus, OFF_CTRL) && bus.wdata[CT_GO] && ctrl_r[CT_FSM];

  // Register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r  <= CTRL_RST;
      baud_r  <= BAUD_RST;
      gdiv_r  <= GDIV_RST;
      fsk_deviation_step_r  <= FSK_DEVIATION_STEP_RST;
      cint_r  <= CINT_RST;
      cfrac_r <= CFRAC_RST;
      asup_r  <= ASUP_RST;
      amp_ramp_time_r <= AMP_RAMP_TIME_RST;
      alo_r   <= ALVL_RST;
      ahi_r   <= ALVL_RST;
      slope_r <= SLOPE_RST;
      rdiv_r  <= RDIV_RST;
      stup_r  <= STUP_RST;
      plen_r  <= PLEN_RST;
    end else begin
      if (wr_hit(bus, OFF_CTRL))  ctrl_r  <= bus.wdata[7:0];
      if (wr_hit(bus, OFF_BAUD))  baud_r  <= bus.wdata[15:0];
      if (wr_hit(bus, OFF_GDIV))  gdiv_r  <= bus.wdata[11:0];
      if (wr_hit(bus, OFF_FSK_DEVIATION_STEP))  fsk_deviation_step_r  <= bus.wdata[7:0];
      if (wr_hit(bus, OFF_CINT))  cint_r  <= bus.wdata[7:0];
      if (wr_hit(bus, OFF_CFRAC)) cfrac_r <= bus.wdata[20:0];
      if (wr_hit(bus, OFF_AMP)) begin
        asup_r  <= bus.wdata[7:0];
        amp_ramp_time_r <= bus.wdata[AMP_AMP_RAMP_TIME +: 8];
      end
      if (wr_hit(bus, OFF_ASKLO)) alo_r   <= bus.wdata[7:0];
      if (wr_hit(bus, OFF_ASKHI)) ahi_r   <= bus.wdata[7:0];
      if (wr_hit(bus, OFF_RAMP)) begin
        slope_r <= bus.wdata[7:0];
        rdiv_r  <= bus.wdata[RAMP_RDIV +: 4];
      end
      if (wr_hit(bus, OFF_STUP))  stup_r  <= bus.wdata[15:0];
      if (wr_hit(bus, OFF_PLEN))  plen_r  <= bus.wdata[7:0];
    end
  end

  // Register reads, data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data_r <= 32'h00000000;
    end else if (!bus.rd) begin
      rd_data_r <= 32'h00000000;
    end else begin
      case (bus.addr)
        OFF_CTRL:   rd_data_r <= {24'h000000, ctrl_r};
        OFF_STATUS: rd_data_r <= {28'h0000000, amp_enable_r, cpu_halt_r,
                                  state_r != ST_IDLE, stable_r};
        OFF_BAUD:   rd_data_r <= {16'h0000, baud_r};
        OFF_GDIV:   rd_data_r <= {20'h00000, gdiv_r};
        OFF_FSK_DEVIATION_STEP:   rd_data_r <= {24'h000000, fsk_deviation_step_r};
        OFF_CINT:   rd_data_r <= {24'h000000, cint_r};
        OFF_CFRAC:  rd_data_r <= {11'h000, cfrac_r};
        OFF_AMP:    rd_data_r <= {16'h0000, amp_ramp_time_r, asup_r};
        OFF_ASKLO:  rd_data_r <= {24'h000000, alo_r};
        OFF_ASKHI:  rd_data_r <= {24'h000000, ahi_r};
        OFF_RAMP:   rd_data_r <= {20'h00000, rdiv_r, slope_r};
        OFF_STUP:   rd_data_r <= {16'h0000, stup_r};
        OFF_PLEN:   rd_data_r <= {24'h000000, plen_r};
        default:    rd_data_r <= 32'h00000000;
      endcase
    end
  end

  // settings follow software only while idle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= '0;
    end else if (state_r == ST_IDLE) begin
      cfg_r <= '{baud: baud_r, gdiv: gdiv_r, fsk_deviation_step: fsk_deviation_step_r, slope: slope_r, rdiv: rdiv_r,
                 amp_ramp_time: amp_ramp_time_r, nrz: ctrl_r[CT_NRZ], gauss: ctrl_r[CT_GAUSS],
                 mode: rftx_mod_type'(ctrl_r[CT_MODE +: 2])};
    end
  end

  // Transmission sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   if (go) state_nxt = ST_START;
      ST_START:  if (wcnt_r == stup_r) state_nxt = ST_FETCH;
      ST_FETCH:  state_nxt = ST_LOAD;
      ST_LOAD:   if (rd_d_r) state_nxt = ST_RAMPUP;
      ST_RAMPUP: if (amp_imp_level_r == imp_tgt) state_nxt = ST_SEND;
      ST_SEND:   if (byte_end && byte_r == plen_r - 8'h01) state_nxt = ST_RAMPDN;
      ST_RAMPDN: if (amp_imp_level_r == 8'h00) state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
    if (!ctrl_r[CT_FSM]) state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rstn) state_r <= ST_IDLE;
    else       state_r <= state_nxt;
  end

  // Oscillator start-up and status
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wcnt_r       <= 16'h0000;
      stable_r     <= 1'b0;
      osc_enable_r <= 1'b0;
    end else begin
      wcnt_r       <= (state_r == ST_START) ? wcnt_r + 16'h0001 : 16'h0000;
      osc_enable_r <= state_nxt != ST_IDLE;
      // flag rises when the wait ends
      if (state_nxt == ST_IDLE)
        stable_r <= 1'b0;
      else if (state_r == ST_START && state_nxt == ST_FETCH)
        stable_r <= 1'b1;
    end
  end

  // chip every 4*(divider+1) clocks, Manchester bit every 8*(divider+1)
  assign chip_tick = (state_r == ST_SEND) && (ccnt_r == {cfg_r.baud, 2'b11});

  always_ff @(posedge clk) begin
    if (!rstn || state_r != ST_SEND || chip_tick) ccnt_r <= 18'h00000;
    else                                          ccnt_r <= ccnt_r + 18'h00001;
  end

  // NRZ spends one chip per bit, Manchester two
  assign byte_end = chip_tick && bit_r == 3'h0 && (cfg_r.nrz || half_r);
  assign enc      = sh_r[bit_r] ^ (half_r && !cfg_r.nrz);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh_r   <= 8'h00;
      pre_r  <= 8'h00;
      bit_r  <= 3'h7;
      half_r <= 1'b0;
      byte_r <= 8'h00;
    end else if (state_r == ST_LOAD && rd_d_r) begin
      sh_r   <= ram_rdata;
      bit_r  <= 3'h7;
      half_r <= 1'b0;
      byte_r <= 8'h00;
    end else begin
      if (rd_d_r) pre_r <= ram_rdata;
      if (chip_tick) begin
        half_r <= !half_r && !cfg_r.nrz;
        if (cfg_r.nrz || half_r) bit_r <= bit_r - 3'h1;
        if (byte_end) begin
          sh_r   <= pre_r;
          byte_r <= byte_r + 8'h01;
        end
      end
    end
  end

  // payload read from RAM_BASE upward, one byte ahead
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ram_rd_r   <= 1'b0;
      ram_addr_r <= 8'h00;
      rd_d_r     <= 1'b0;
    end else begin
      rd_d_r   <= ram_rd_r;
      ram_rd_r <= 1'b0;
      if (state_r == ST_FETCH) begin
        ram_rd_r   <= 1'b1;
        ram_addr_r <= RAM_BASE;
      end else if ((state_r == ST_LOAD && rd_d_r) || byte_end) begin
        ram_rd_r   <= 1'b1;
        ram_addr_r <= ram_addr_r + 8'h01;
      end
    end
  end

  // processor held while the controller runs
  always_ff @(posedge clk) begin
    if (!rstn) cpu_halt_r <= 1'b0;
    else       cpu_halt_r <= state_nxt != ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rstn) mod_data_r <= 1'b0;
    else       mod_data_r <= (state_r == ST_SEND) && enc;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gcnt_r <= 12'h000;
      hist_r <= 4'h0;
    end else if (gcnt_r == cfg_r.gdiv) begin
      gcnt_r <= 12'h000;
      hist_r <= {hist_r[2:0], mod_data_r};
    end else begin
      gcnt_r <= gcnt_r + 12'h001;
    end
  end

  // weights 1, 4, 4, 1 over the last four samples
  assign wsum = {3'h0, hist_r[0]} + {3'h0, hist_r[3]} +
                {2'h0, hist_r[1], hist_r[1]} + {3'h0, hist_r[1]} +
                {2'h0, hist_r[2], hist_r[2]} + {3'h0, hist_r[2]};

  always_comb begin
    if (cfg_r.mode != MOD_FSK) w = W_MID;
    else if (cfg_r.gauss)      w = wsum;
    else                       w = mod_data_r ? W_TOP : 4'h0;
  end

  // offset of deviation times 95, scaled by weight
  assign dev     = 15'(cfg_r.fsk_deviation_step * DEV_MULT);
  assign prod    = 21'($signed({1'b0, dev})) * 21'($signed({1'b0, w}) - 5'sh04);
  // center word in steps of crystal over 2^23
  assign cw      = {cint_r, cfrac_r, 2'b00};
  assign sdm_nxt = cw + 31'(prod >>> 2);

  always_ff @(posedge clk) begin
    if (!rstn) sdm_freq_word_r <= 31'h00000000;
    else       sdm_freq_word_r <= sdm_nxt;
  end

  assign tx_on = ctrl_r[CT_FSM] ? (state_r == ST_RAMPUP || state_r == ST_SEND)
                                : ctrl_r[CT_AMPMAN];
  assign imp_tgt = tx_on ? IMP_FULL : 8'h00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      amp_enable_r       <= 1'b0;
      amp_bypass_r       <= 1'b0;
      osc_boost_enable_r <= 1'b0;
    end else begin
      amp_enable_r       <= ctrl_r[CT_FSM] ? (state_nxt == ST_RAMPUP || state_nxt == ST_SEND
                                              || state_nxt == ST_RAMPDN) : ctrl_r[CT_AMPMAN];
      amp_bypass_r       <= ctrl_r[CT_BYPASS];
      osc_boost_enable_r <= ctrl_r[CT_BOOST];
    end
  end

  // FSK impedance ramp, one step per ramp time plus one clocks
  always_ff @(posedge clk) begin
    if (!rstn) begin
      icnt_r          <= 8'h00;
      amp_imp_level_r <= 8'h00;
    end else if (cfg_r.mode != MOD_FSK) begin
      icnt_r          <= 8'h00;
      amp_imp_level_r <= imp_tgt;
    end else if (amp_imp_level_r == imp_tgt || icnt_r != cfg_r.amp_ramp_time) begin
      icnt_r <= (amp_imp_level_r == imp_tgt) ? 8'h00 : icnt_r + 8'h01;
    end else begin
      icnt_r          <= 8'h00;
      amp_imp_level_r <= tx_on ? amp_imp_level_r + 8'h01 : amp_imp_level_r - 8'h01;
    end
  end

  // trapezoid between low and high levels
  always_comb begin
    if (state_r == ST_SEND) ask_tgt = mod_data_r ? ahi_r : alo_r;
    else                    ask_tgt = tx_on ? alo_r : 8'h00;
  end

  rftx_ramp #(.LW(8)) u_ramp (
    .clk      (clk),
    .rstn     (rstn),
    .target   (ask_tgt),
    .slope    (cfg_r.slope),
    .rate_div (cfg_r.rdiv),
    .level_r  (ask_lvl)
  );

  // constant supply for FSK and OOK
  always_ff @(posedge clk) begin
    if (!rstn)                     amp_supply_pin_r <= 8'h00;
    else if (cfg_r.mode == MOD_ASK) amp_supply_pin_r <= ask_lvl;
    else                           amp_supply_pin_r <= tx_on ? asup_r : 8'h00;
  end

  fsk_tone_a: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_r.mode == MOD_FSK && !cfg_r.gauss && mod_data_r)
      |=> sdm_freq_word_r == $past(cw) + 31'($past(dev)))
    else $error("upper tone word wrong");
  halt_busy_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_r != ST_IDLE && $past(state_r) != ST_IDLE) |-> cpu_halt_r)
    else $error("processor not halted during transfer");
  pa_manual_a: assert property (@(posedge clk) disable iff (!rstn)
    (!ctrl_r[CT_FSM] && $stable(ctrl_r)) |=> amp_enable_r == $past(ctrl_r[CT_AMPMAN]))
    else $error("manual amplifier enable not followed");
  bypass_pin_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(ctrl_r[CT_BYPASS]) |=> amp_bypass_r == $past(ctrl_r[CT_BYPASS]))
    else $error("bypass not applied");
  supply_const_a: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl_r[CT_FSM] && cfg_r.mode != MOD_ASK && state_r == ST_SEND)
      |=> amp_supply_pin_r == $past(asup_r))
    else $error("supply level not constant");
  ram_base_a: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_FETCH |=> ram_rd_r && ram_addr_r == RAM_BASE)
    else $error("payload fetch not at base");
  start_wait_a: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl_r[CT_FSM] && state_r == ST_START && wcnt_r != stup_r)
      |=> !stable_r ##0 state_r == ST_START)
    else $error("start-up wait cut short");
  cfg_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_r != ST_IDLE && $past(state_r) != ST_IDLE) |-> $stable(cfg_r))
    else $error("settings changed mid transmission");
  chip_gap_a: assert property (@(posedge clk) disable iff (!rstn)
    chip_tick |=> !chip_tick [*3])
    else $error("chip period below four clocks");

  send_seen_c:  cover property (@(posedge clk) disable iff (!rstn) state_r == ST_SEND);
  byte_next_c:  cover property (@(posedge clk) disable iff (!rstn)
    byte_end && state_nxt == ST_SEND);
  done_c:       cover property (@(posedge clk) disable iff (!rstn)
    state_r == ST_RAMPDN ##1 state_r == ST_IDLE);
endmodule // rftx_ctrl

// ### verilog/rftx_pkg.sv
package rftx_pkg;
  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_BAUD   = 8'h08;
  localparam logic [7:0] OFF_GDIV   = 8'h0c;
  localparam logic [7:0] OFF_FSK_DEVIATION_STEP   = 8'h10;
  localparam logic [7:0] OFF_CINT   = 8'h14;
  localparam logic [7:0] OFF_CFRAC  = 8'h18;
  localparam logic [7:0] OFF_AMP    = 8'h1c;
  localparam logic [7:0] OFF_ASKLO  = 8'h20;
  localparam logic [7:0] OFF_ASKHI  = 8'h24;
  localparam logic [7:0] OFF_RAMP   = 8'h28;
  localparam logic [7:0] OFF_STUP   = 8'h2c;
  localparam logic [7:0] OFF_PLEN   = 8'h30;

  // Control register fields
  localparam int CT_FSM    = 0;
  localparam int CT_AMPMAN = 1;
  localparam int CT_BYPASS = 2;
  localparam int CT_BOOST  = 3;
  localparam int CT_GAUSS  = 4;
  localparam int CT_NRZ    = 5;
  localparam int CT_MODE   = 6;
  localparam int CT_GO     = 8;

  // Amplifier and ramp register fields
  localparam int AMP_AMP_RAMP_TIME = 8;
  localparam int RAMP_RDIV = 8;

  // Values after reset
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] BAUD_RST  = 16'h0050;
  localparam logic [11:0] GDIV_RST  = 12'h013;
  localparam logic [7:0]  FSK_DEVIATION_STEP_RST  = 8'h00;
  localparam logic [7:0]  CINT_RST  = 8'h00;
  localparam logic [20:0] CFRAC_RST = 21'h000000;
  localparam logic [7:0]  ASUP_RST  = 8'h00;
  localparam logic [7:0]  AMP_RAMP_TIME_RST = 8'h00;
  localparam logic [7:0]  ALVL_RST  = 8'h00;
  localparam logic [7:0]  SLOPE_RST = 8'h01;
  localparam logic [3:0]  RDIV_RST  = 4'h0;
  localparam logic [15:0] STUP_RST  = 16'h0100;
  localparam logic [7:0]  PLEN_RST  = 8'h01;

  // Fixed numbers of the payload fetch, amplifier and modulation path
  localparam logic [7:0]  RAM_BASE = 8'h80;
  localparam logic [14:0] DEV_MULT = 15'h005f;
  localparam logic [7:0]  IMP_FULL = 8'hff;
  localparam logic [3:0]  W_MID    = 4'h4;
  localparam logic [3:0]  W_TOP    = 4'h8;

  typedef enum logic [1:0] {MOD_FSK, MOD_OOK, MOD_ASK} rftx_mod_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rftx_bus_type;

  typedef struct packed {
    logic [15:0]  baud;
    logic [11:0]  gdiv;
    logic [7:0]   fsk_deviation_step;
    logic [7:0]   slope;
    logic [3:0]   rdiv;
    logic [7:0]   amp_ramp_time;
    logic         nrz;
    logic         gauss;
    rftx_mod_type mode;
  } rftx_cfg_type;
endpackage

// ### verilog/rftx_ramp.sv
`timescale 1ns/1ps
module rftx_ramp #(
  parameter int LW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Ramp settings
  input  wire logic [LW-1:0] target,
  input  wire logic [LW-1:0] slope,
  input  wire logic [3:0]    rate_div,
  // Supply level
  output logic      [LW-1:0] level_r
);
  logic [3:0]  acc_r;
  logic [4:0]  acc_sum;
  logic [LW:0] step;
  logic [LW:0] gap;

  assign acc_sum = {1'b0, acc_r} + {1'b0, rate_div} + 5'h01;
  assign step    = {1'b0, slope} + {{LW{1'b0}}, acc_sum[4]};
  assign gap     = (level_r < target) ? {1'b0, target - level_r} : {1'b0, level_r - target};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_r   <= 4'h0;
      level_r <= '0;
    end else begin
      acc_r <= acc_sum[3:0];
      if (gap <= step) begin
        level_r <= target;
      end else if (level_r < target) begin
        level_r <= level_r + step[LW-1:0];
      end else begin
        level_r <= level_r - step[LW-1:0];
      end
    end
  end

  no_overshoot_a: assert property (@(posedge clk) disable iff (!rstn)
    ($stable(target) && level_r <= target) |=> level_r <= $past(target))
    else $error("ramp level passed its target");

  ramp_arrive_a: assert property (@(posedge clk) disable iff (!rstn)
    (gap <= step) |=> level_r == $past(target))
    else $error("ramp did not settle on target");
endmodule // rftx_ramp

// ### testbench/rftx_ram_model.sv
`timescale 1ns/1ps
module rftx_ram_model (
  // Clock
  input  wire logic       clk,
  // Controller side
  input  wire logic [7:0] ram_addr_r,
  input  wire logic       ram_rd_r,
  input  wire logic       cpu_halt_r,
  // Read data
  output logic      [7:0] ram_rdata
);
  logic [7:0] mem [256];

  initial ram_rdata = 8'h00;

  // halted fetch only
  // Outside a fetch the data toggles so a stale byte is never mistaken for a good one
  always @(posedge clk) begin
    if (ram_rd_r && cpu_halt_r) begin
      ram_rdata <= mem[ram_addr_r];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule // rftx_ram_model

// ### testbench/rftx_ctrl_tb_top.sv
`timescale 1ns/1ps
module rftx_ctrl_tb_top;
  import rftx_pkg::*;
  localparam int CHIP = 16;
  logic         clk;
  logic         rstn;
  rftx_bus_type bus;
  logic [31:0]  rd_data_r;
  logic [7:0]   ram_addr_r;
  logic         ram_rd_r;
  logic [7:0]   ram_rdata;
  logic         cpu_halt_r;
  logic         osc_enable_r;
  logic         osc_boost_enable_r;
  logic         amp_enable_r;
  logic         amp_bypass_r;
  logic [7:0]   amp_imp_level_r;
  logic [7:0]   amp_supply_pin_r;
  logic         mod_data_r;
  logic [30:0]  sdm_freq_word_r;
  logic [31:0]  exp_q[$];
  int           err_count = 0;
  int           total_checks = 0;
  int           cyc = 0;
  logic         rd_prev = 1'b0;
  logic [7:0]   byte_v;
  logic [7:0]   fsk_deviation_step_v;
  logic [7:0]   cint_v;
  logic [20:0]  cfrac_v;
  logic [30:0]  base_v;
  logic [30:0]  dev_v;
  logic [31:0]  ctl_v;
  logic         chip_v;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  rftx_ctrl dut (
    .clk(clk), .rstn(rstn), .bus(bus), .rd_data_r(rd_data_r),
    .ram_addr_r(ram_addr_r), .ram_rd_r(ram_rd_r), .ram_rdata(ram_rdata),
    .cpu_halt_r(cpu_halt_r), .osc_enable_r(osc_enable_r),
    .osc_boost_enable_r(osc_boost_enable_r), .amp_enable_r(amp_enable_r),
    .amp_bypass_r(amp_bypass_r), .amp_imp_level_r(amp_imp_level_r),
    .amp_supply_pin_r(amp_supply_pin_r), .mod_data_r(mod_data_r),
    .sdm_freq_word_r(sdm_freq_word_r)
  );

  rftx_ram_model ram (
    .clk(clk), .ram_addr_r(ram_addr_r), .ram_rd_r(ram_rd_r),
    .cpu_halt_r(cpu_halt_r), .ram_rdata(ram_rdata)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One strobe cycle, then an idle cycle so no strobe is assigned twice in a step
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(a, 32'h0, 1'b0);
  endtask

  task automatic wait_sig(ref logic s, input logic v, input string name);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(name, {31'h0, s}, {31'h0, v});
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_prev <= bus.rd;
    if (rd_prev === 1'b1) begin
      check("rd_data_r", rd_data_r, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    bus = '0;
    rstn = 1'b0;
    void'($urandom(56));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, {24'h0, CTRL_RST});
    rd(OFF_STATUS, 32'h0);
    rd(OFF_BAUD, {16'h0, BAUD_RST});
    rd(OFF_GDIV, {20'h0, GDIV_RST});
    rd(OFF_RAMP, {20'h0, RDIV_RST, SLOPE_RST});
    rd(OFF_STUP, {16'h0, STUP_RST});
    rd(OFF_PLEN, {24'h0, PLEN_RST});
    acc(8'h3c, 32'hffffffff, 1'b1);
    rd(8'h3c, 32'h0);
    check("osc_boost_enable_r", {31'h0, osc_boost_enable_r}, 32'h0);
    acc(OFF_CTRL, 32'h100, 1'b1);
    check("osc_enable_r", {31'h0, osc_enable_r}, 32'h0);
    fsk_deviation_step_v = 8'($urandom);
    cint_v = 8'($urandom);
    cfrac_v = 21'($urandom);
    acc(OFF_FSK_DEVIATION_STEP, {24'h0, fsk_deviation_step_v}, 1'b1);
    acc(OFF_CINT, {24'h0, cint_v}, 1'b1);
    acc(OFF_CFRAC, {11'h0, cfrac_v}, 1'b1);
    acc(OFF_BAUD, 32'h3, 1'b1);
    acc(OFF_STUP, 32'h4, 1'b1);
    acc(OFF_AMP, 32'h40, 1'b1);
    rd(OFF_FSK_DEVIATION_STEP, {24'h0, fsk_deviation_step_v});
    rd(OFF_CFRAC, {11'h0, cfrac_v});
    base_v = {cint_v, cfrac_v, 2'b00};
    dev_v = {23'h0, fsk_deviation_step_v} * 31'h5f;
    for (int n = 0; n < 2; n++) begin
      byte_v = 8'($urandom) | 8'h80;
      ram.mem[8'h80] = byte_v;
      ram.mem[8'h81] = ~byte_v;
      ctl_v = {26'h0, n[0], (n == 0) ? 5'h0d : 5'h09};
      acc(OFF_CTRL, ctl_v, 1'b1);
      acc(OFF_CTRL, ctl_v | 32'h100, 1'b1);
      check("osc_boost_enable_r", {31'h0, osc_boost_enable_r}, 32'h1);
      check("amp_bypass_r", {31'h0, amp_bypass_r}, {31'h0, n == 0});
      check("osc_enable_r", {31'h0, osc_enable_r}, 32'h1);
      wait_sig(ram_rd_r, 1'b1, "ram_rd_r");
      check("ram_addr_r", {24'h0, ram_addr_r}, 32'h80);
      check("cpu_halt_r", {31'h0, cpu_halt_r}, 32'h1);
      wait_sig(mod_data_r, 1'b1, "mod_data_r");
      check("amp_imp_level_r", {24'h0, amp_imp_level_r}, 32'hff);
      rd(OFF_STATUS, 32'hf);
      repeat (5) @(posedge clk);
      for (int k = 0; k < ((n == 1) ? 8 : 16); k++) begin
        chip_v = (n == 1) ? byte_v[7-k] : byte_v[7-k/2] ^ k[0];
        check("mod_data_r", {31'h0, mod_data_r}, {31'h0, chip_v});
        check("sdm_freq_word_r", {1'b0, sdm_freq_word_r},
              {1'b0, chip_v ? base_v + dev_v : base_v - dev_v});
        check("amp_supply_pin_r", {24'h0, amp_supply_pin_r}, 32'h40);
        repeat (CHIP) @(posedge clk);
      end
      wait_sig(cpu_halt_r, 1'b0, "cpu_halt_r");
      check("amp_imp_level_r", {24'h0, amp_imp_level_r}, 32'h0);
      rd(OFF_STATUS, 32'h0);
    end
    // Abort by clearing the enable bit during the start-up wait
    acc(OFF_CTRL, 32'h129, 1'b1);
    acc(OFF_CTRL, 32'h0, 1'b1);
    rd(OFF_STATUS, 32'h0);
    check("osc_enable_r", {31'h0, osc_enable_r}, 32'h0);
    // Processor mode, ASK: manual amplifier switch, supply ramp of two steps per clock
    acc(OFF_ASKLO, 32'h30, 1'b1);
    acc(OFF_RAMP, 32'hf01, 1'b1);
    acc(OFF_CTRL, 32'h82, 1'b1);
    repeat (10) @(posedge clk);
    check("amp_supply_pin_r", {24'h0, amp_supply_pin_r}, 32'h12);
    repeat (20) @(posedge clk);
    check("amp_supply_pin_r", {24'h0, amp_supply_pin_r}, 32'h30);
    check("amp_enable_r", {31'h0, amp_enable_r}, 32'h1);
    check("amp_imp_level_r", {24'h0, amp_imp_level_r}, 32'hff);
    acc(OFF_CTRL, 32'h80, 1'b1);
    repeat (30) @(posedge clk);
    check("amp_supply_pin_r", {24'h0, amp_supply_pin_r}, 32'h0);
    check("amp_enable_r", {31'h0, amp_enable_r}, 32'h0);
    end_sim();
  end
endmodule // rftx_ctrl_tb_top
